//--- gppc_consts.svh
`ifndef GPPC_CONSTS_SVH
`define GPPC_CONSTS_SVH

// ----------------------------------------------------------------
// port layout
// ----------------------------------------------------------------
`define GPPC_NPORT        5
`define GPPC_PINS         8
`define GPPC_IMPL_MASK    40'hFF3F3FFFFF

// ----------------------------------------------------------------
// register byte offsets within a port window of 64 bytes
// ----------------------------------------------------------------
`define GPPC_PORT_LSB     6
`define GPPC_OFS_DOUT     6'h00
`define GPPC_OFS_STATE    6'h04
`define GPPC_OFS_MODE     6'h08
`define GPPC_OFS_BUF      6'h0C
`define GPPC_OFS_CFG      6'h10
`define GPPC_OFS_MUX      6'h14
`define GPPC_OFS_EDGE     6'h18
`define GPPC_OFS_ISTAT    6'h1C
`define GPPC_OFS_ICLR     6'h20
`define GPPC_OFS_IEN      6'h24

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GPPC_BUF_OE_LSB   8
`define GPPC_CFG_LVTTL    0
`define GPPC_CFG_SLOW     1
`define GPPC_RST_DOUT     8'h00
`define GPPC_RST_MODE     24'h000000
`define GPPC_RST_BUF      16'h0000
`define GPPC_RST_CFG      2'h0
`define GPPC_RST_MUX      16'h0000
`define GPPC_RST_EDGE     16'h0000
`define GPPC_RST_IEN      8'h00

`endif

//--- gppc_pkg.sv
package gppc_pkg;

    typedef enum logic [2:0]
    {
        GPPC_ANALOG,
        GPPC_INPUT,
        GPPC_WUP_SDN,
        GPPC_SUP_WDN,
        GPPC_OD_LOW,
        GPPC_OD_HIGH,
        GPPC_STRONG,
        GPPC_WEAK
    } gppc_mode_type;

    typedef enum logic [1:0]
    {
        GPPC_EDGE_NONE,
        GPPC_EDGE_RISE,
        GPPC_EDGE_FALL,
        GPPC_EDGE_BOTH
    } gppc_edge_type;

endpackage : gppc_pkg

//--- gppc_drive.sv
`timescale 1ns/10ps
`default_nettype none

module gppc_drive
(
    input  wire logic [23:0] mode_i,
    input  wire logic [7:0]  dout_i,
    input  wire logic [7:0]  alt1_i,
    input  wire logic [7:0]  alt2_i,
    input  wire logic [7:0]  alt3_i,
    input  wire logic [15:0] mux_i,
    input  wire logic [7:0]  ibuf_i,
    input  wire logic [7:0]  obuf_i,
    input  wire logic [7:0]  impl_i,
    output logic      [7:0]  val_o,
    output logic      [7:0]  strong_o,
    output logic      [7:0]  pu_o,
    output logic      [7:0]  pd_o,
    output logic      [7:0]  ie_o
);

    // ----------------------------------------------------------------
    // per-pin mode decode: {strong, weak up, weak down}
    // ----------------------------------------------------------------
    function automatic logic [2:0] decode(input logic [2:0] m, input logic v);
        case (gppc_pkg::gppc_mode_type'(m))
            gppc_pkg::GPPC_WUP_SDN: decode = {~v, v, 1'b0};
            gppc_pkg::GPPC_SUP_WDN: decode = {v, 1'b0, ~v};
            gppc_pkg::GPPC_OD_LOW:  decode = {~v, 2'b00};
            gppc_pkg::GPPC_OD_HIGH: decode = {v, 2'b00};
            gppc_pkg::GPPC_STRONG:  decode = 3'h4;
            gppc_pkg::GPPC_WEAK:    decode = {1'b0, v, ~v};
            default:                decode = 3'h0;
        endcase
    endfunction : decode

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            wire logic [1:0] sel = mux_i[2*i +: 2];
            wire logic       v   = (sel == 2'h0) ? dout_i[i] :
                                   (sel == 2'h1) ? alt1_i[i] :
                                   (sel == 2'h2) ? alt2_i[i] : alt3_i[i];
            wire logic [2:0] d   = decode(mode_i[3*i +: 3], v);
            wire logic       oen = obuf_i[i] & impl_i[i];
            assign val_o[i]    = v;
            assign strong_o[i] = d[2] & oen;
            assign pu_o[i]     = d[1] & oen;
            assign pd_o[i]     = d[0] & oen;
            assign ie_o[i]     = ibuf_i[i] & impl_i[i] &
                                 (mode_i[3*i +: 3] != 3'(gppc_pkg::GPPC_ANALOG));
        end
    endgenerate

endmodule : gppc_drive

`default_nettype wire

//--- gppc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module gppc_sync
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  pin_i,
    input  wire logic [7:0]  ie_i,
    input  wire logic [15:0] edge_i,
    input  wire logic [7:0]  clr_i,
    output logic      [7:0]  state_o,
    output logic      [7:0]  flag_o
);

    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] prev_r;
    logic [7:0] flag_r;
    logic [7:0] set_w;

    // input buffer off reads low, like a dead input stage
    wire logic [7:0] lvl = s2_r & ie_i;

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_edge
            wire logic rise = lvl[i] & ~prev_r[i];
            wire logic fall = ~lvl[i] & prev_r[i];
            assign set_w[i] = (rise & edge_i[2*i]) | (fall & edge_i[2*i+1]);
        end
    endgenerate

    // set beats clear so a coincident edge is never lost
    wire logic [7:0] flag_nxt = (flag_r & ~clr_i) | set_w;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_r   <= 8'h00;
            s2_r   <= 8'h00;
            prev_r <= 8'h00;
            flag_r <= 8'h00;
        end
        else
        begin
            s1_r   <= pin_i;
            s2_r   <= s1_r;
            prev_r <= lvl;
            flag_r <= flag_nxt;
        end
    end

    assign state_o = lvl;
    assign flag_o  = flag_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // the release edge still clears the chain, so only start after it
    a_sync_two_ff: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i |-> ##2 (s2_r == $past(pin_i, 2)))
        else $error("pin synchroniser is not two stages");

    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ((set_w & clr_i) != 8'h00)
        |=> ((flag_r & $past(set_w & clr_i)) == $past(set_w & clr_i)))
        else $error("clear beat a coincident edge");

    a_rise_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (edge_i[2] && $rose(lvl[1]) && !$past(rst_i)) |=> flag_r[1])
        else $error("rising edge did not set flag");

endmodule : gppc_sync

`default_nettype wire

//--- gppc_top.sv
// Contract
// - eight drive modes per pin
// - five ports, ports 2 and 3 narrower
// - reset holds all buffers disabled
// - pins driven from data out; state readable
// - per-pin interrupts merged into five port lines
// - separate input and output buffer enables
// - selectable CMOS or LVTTL input threshold
// - selectable output slew rate
// - per-pin source multiplexer
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "gppc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module gppc_top
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic      [31:0] PRDATA_O,
    output logic             PSLVERR_O,
    input  wire logic [39:0] PIN_I,
    input  wire logic [39:0] ALT1_I,
    input  wire logic [39:0] ALT2_I,
    input  wire logic [39:0] ALT3_I,
    output logic      [39:0] PIN_O,
    output logic      [39:0] PIN_OE_O,
    output logic      [39:0] PIN_PU_O,
    output logic      [39:0] PIN_PD_O,
    output logic      [39:0] PIN_IE_O,
    output logic      [4:0]  PIN_LVTTL_O,
    output logic      [4:0]  PIN_SLOW_O,
    output logic      [4:0]  IRQ_O
);

    localparam int NPORT = `GPPC_NPORT;
    localparam logic [39:0] IMPL = `GPPC_IMPL_MASK;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0]  dout_r [NPORT];
    logic [23:0] mode_r [NPORT];
    logic [15:0] buf_r  [NPORT];
    logic [1:0]  cfg_r  [NPORT];
    logic [15:0] mux_r  [NPORT];
    logic [15:0] edge_r [NPORT];
    logic [7:0]  ien_r  [NPORT];

    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;

    logic [39:0] val_w;
    logic [39:0] strong_w;
    logic [39:0] pu_w;
    logic [39:0] pd_w;
    logic [39:0] ie_w;
    logic [39:0] state_w;
    logic [39:0] flag_w;
    logic [4:0]  irq_nxt;
    logic [4:0]  lvttl_nxt;
    logic [4:0]  slow_nxt;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire logic [2:0] sel_port = PADDR_I[8:`GPPC_PORT_LSB];
    wire logic [5:0] sel_ofs  = PADDR_I[5:0];
    wire logic       port_ok  = (PADDR_I[11:9] == 3'h0) && (sel_port < 3'(NPORT));
    wire logic       ofs_ok   = (sel_ofs[1:0] == 2'h0) && (sel_ofs <= `GPPC_OFS_IEN);
    wire logic       mapped   = port_ok & ofs_ok;
    wire logic       setup    = PSEL_I & PENABLE_I & ~pready_r;
    // write lands on the edge that samples pready high
    wire logic       acc      = PSEL_I & PENABLE_I & pready_r;
    wire logic       wr       = acc & PWRITE_I & mapped;
    wire logic [2:0] pi       = port_ok ? sel_port : 3'h0;

    wire logic [31:0] rd_w =
        (sel_ofs == `GPPC_OFS_DOUT)  ? {24'h000000, dout_r[pi]} :
        (sel_ofs == `GPPC_OFS_STATE) ? {24'h000000, state_w[8*pi +: 8]} :
        (sel_ofs == `GPPC_OFS_MODE)  ? {8'h00, mode_r[pi]} :
        (sel_ofs == `GPPC_OFS_BUF)   ? {16'h0000, buf_r[pi]} :
        (sel_ofs == `GPPC_OFS_CFG)   ? {30'h00000000, cfg_r[pi]} :
        (sel_ofs == `GPPC_OFS_MUX)   ? {16'h0000, mux_r[pi]} :
        (sel_ofs == `GPPC_OFS_EDGE)  ? {16'h0000, edge_r[pi]} :
        (sel_ofs == `GPPC_OFS_ISTAT) ? {24'h000000, flag_w[8*pi +: 8]} :
        (sel_ofs == `GPPC_OFS_IEN)   ? {24'h000000, ien_r[pi]} : 32'h00000000;

    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setup;
            prdata_r  <= setup ? (mapped ? rd_w : 32'h00000000) : prdata_r;
            pslverr_r <= setup & ~mapped;
        end
    end

    // ----------------------------------------------------------------
    // per-port registers, pin cells and interrupt flags
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NPORT; p++)
        begin : g_port
            wire logic hit = wr && (sel_port == 3'(p));
            wire logic [7:0] clr = (hit && sel_ofs == `GPPC_OFS_ICLR) ?
                                   PWDATA_I[7:0] : 8'h00;

            always_ff @(posedge CLOCK_I or posedge RST_I)
            begin
                if (RST_I)
                begin
                    dout_r[p] <= `GPPC_RST_DOUT;
                    mode_r[p] <= `GPPC_RST_MODE;
                    buf_r[p]  <= `GPPC_RST_BUF;
                    cfg_r[p]  <= `GPPC_RST_CFG;
                    mux_r[p]  <= `GPPC_RST_MUX;
                    edge_r[p] <= `GPPC_RST_EDGE;
                    ien_r[p]  <= `GPPC_RST_IEN;
                end
                else if (hit)
                begin
                    if (sel_ofs == `GPPC_OFS_DOUT)
                        dout_r[p] <= PWDATA_I[7:0];
                    if (sel_ofs == `GPPC_OFS_MODE)
                        mode_r[p] <= PWDATA_I[23:0];
                    if (sel_ofs == `GPPC_OFS_BUF)
                        buf_r[p]  <= PWDATA_I[15:0];
                    if (sel_ofs == `GPPC_OFS_CFG)
                        cfg_r[p]  <= PWDATA_I[1:0];
                    if (sel_ofs == `GPPC_OFS_MUX)
                        mux_r[p]  <= PWDATA_I[15:0];
                    if (sel_ofs == `GPPC_OFS_EDGE)
                        edge_r[p] <= PWDATA_I[15:0];
                    if (sel_ofs == `GPPC_OFS_IEN)
                        ien_r[p]  <= PWDATA_I[7:0];
                end
            end

            gppc_drive u_drive
            (
                .mode_i   (mode_r[p]),
                .dout_i   (dout_r[p]),
                .alt1_i   (ALT1_I[8*p +: 8]),
                .alt2_i   (ALT2_I[8*p +: 8]),
                .alt3_i   (ALT3_I[8*p +: 8]),
                .mux_i    (mux_r[p]),
                .ibuf_i   (buf_r[p][7:0]),
                .obuf_i   (buf_r[p][`GPPC_BUF_OE_LSB +: 8]),
                .impl_i   (IMPL[8*p +: 8]),
                .val_o    (val_w[8*p +: 8]),
                .strong_o (strong_w[8*p +: 8]),
                .pu_o     (pu_w[8*p +: 8]),
                .pd_o     (pd_w[8*p +: 8]),
                .ie_o     (ie_w[8*p +: 8])
            );

            gppc_sync u_sync
            (
                .clk_i   (CLOCK_I),
                .rst_i   (RST_I),
                .pin_i   (PIN_I[8*p +: 8]),
                .ie_i    (PIN_IE_O[8*p +: 8]),
                .edge_i  (edge_r[p]),
                .clr_i   (clr),
                .state_o (state_w[8*p +: 8]),
                .flag_o  (flag_w[8*p +: 8])
            );

            assign irq_nxt[p]   = |(flag_w[8*p +: 8] & ien_r[p]);
            assign lvttl_nxt[p] = cfg_r[p][`GPPC_CFG_LVTTL];
            assign slow_nxt[p]  = cfg_r[p][`GPPC_CFG_SLOW];
        end
    endgenerate

    // ----------------------------------------------------------------
    // pad registers: all buffers off under reset
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PIN_O       <= 40'h0000000000;
            PIN_OE_O    <= 40'h0000000000;
            PIN_PU_O    <= 40'h0000000000;
            PIN_PD_O    <= 40'h0000000000;
            PIN_IE_O    <= 40'h0000000000;
            PIN_LVTTL_O <= 5'h00;
            PIN_SLOW_O  <= 5'h00;
            IRQ_O       <= 5'h00;
        end
        else
        begin
            PIN_O       <= val_w;
            PIN_OE_O    <= strong_w;
            PIN_PU_O    <= pu_w;
            PIN_PD_O    <= pd_w;
            PIN_IE_O    <= ie_w;
            PIN_LVTTL_O <= lvttl_nxt;
            PIN_SLOW_O  <= slow_nxt;
            IRQ_O       <= irq_nxt;
        end
    end

    assign PREADY_O  = pready_r;
    assign PRDATA_O  = prdata_r;
    assign PSLVERR_O = pslverr_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_reset_off: assert property (@(posedge CLOCK_I)
        $fell(RST_I) |-> (PIN_OE_O == 40'h0 && PIN_PU_O == 40'h0 &&
                          PIN_PD_O == 40'h0 && PIN_IE_O == 40'h0))
        else $error("pin buffers active at reset release");

    a_unimpl_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        ((PIN_OE_O | PIN_PU_O | PIN_PD_O | PIN_IE_O) & ~IMPL) == 40'h0)
        else $error("absent pin is enabled");

    a_od_low: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (mode_r[1][2:0] == 3'(gppc_pkg::GPPC_OD_LOW)) |=> !(PIN_OE_O[8] && PIN_O[8]))
        else $error("open drain low drove high");

    a_dout_pin: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr && sel_port == 3'h1 && sel_ofs == `GPPC_OFS_DOUT && mux_r[1][1:0] == 2'h0)
        |=> ##1 (PIN_O[8] == $past(PWDATA_I[0], 2)))
        else $error("data out not on pin");

    a_state_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (setup && !PWRITE_I && PADDR_I == 12'h104)
        |=> (PRDATA_O[7:0] == $past(state_w[39:32])))
        else $error("pin state read wrong");

    a_ibuf_off: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        !buf_r[4][4] |=> !PIN_IE_O[36])
        else $error("input buffer on while disabled");

    a_lvttl_cfg: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        ##1 (PIN_LVTTL_O[1] == $past(cfg_r[1][`GPPC_CFG_LVTTL])))
        else $error("threshold select not applied");

    a_slew_cfg: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        ##1 (PIN_SLOW_O[1] == $past(cfg_r[1][`GPPC_CFG_SLOW])))
        else $error("slew select not applied");

    a_mux_alt: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (mux_r[1][1:0] == 2'h1) |=> (PIN_O[8] == $past(ALT1_I[8])))
        else $error("source mux not honoured");

    a_irq_level: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        ##1 (IRQ_O[3] == $past(|(flag_w[31:24] & ien_r[3]))))
        else $error("port request does not follow flags");

    a_clear_flag: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr && sel_port == 3'h3 && sel_ofs == `GPPC_OFS_ICLR &&
         PWDATA_I[1])
        |=> (!flag_w[25] || $past(g_port[3].u_sync.set_w[1])))
        else $error("flag clear ignored");

    a_apb_answer: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        setup |=> (PREADY_O ##1 !PREADY_O))
        else $error("apb answer not one cycle");

endmodule : gppc_top

`default_nettype wire

//--- gppc_ext_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// board and pad model for all 40 pins
// ----------------------------------------------------------------
module gppc_ext_model
(
    input  wire logic        clk_i,
    input  wire logic [39:0] pin_o_i,
    input  wire logic [39:0] oe_i,
    input  wire logic [39:0] pu_i,
    input  wire logic [39:0] pd_i,
    input  wire logic [39:0] drv_en_i,
    input  wire logic [39:0] drv_val_i,
    output logic      [39:0] pin_i_o
);
    logic [39:0] float_r = 40'h5555555555;

    // a floating pad wanders, so a missing pull or drive cannot hide
    always_ff @(posedge clk_i)
    begin
        float_r <= ~float_r;
    end

    // strong drive wins, then the board, then the weak pulls
    assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & drv_en_i & drv_val_i)
                   | (~oe_i & ~drv_en_i & (pu_i | (~pd_i & float_r)));

endmodule : gppc_ext_model

`default_nettype wire

//--- gpio_port_pin_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "gppc_consts.svh"

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module gpio_port_pin_control_tb;
    logic        clk, rst, psel, pen, pwr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata;
    logic [39:0] alt1, alt2, alt3, ext_en, ext_val;
    wire         pready, pslverr;
    wire  [31:0] prdata;
    wire  [39:0] pin_i, pin_o, oe, pu, pd, ie;
    wire  [4:0]  lvttl, slow, irq;
    int          n_errors, tests_run;
    int          m_reg [5][10];
    logic [39:0] impl = `GPPC_IMPL_MASK;

    gppc_top u_gppc_top (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .PIN_I(pin_i), .ALT1_I(alt1),
        .ALT2_I(alt2), .ALT3_I(alt3), .PIN_O(pin_o), .PIN_OE_O(oe), .PIN_PU_O(pu),
        .PIN_PD_O(pd), .PIN_IE_O(ie), .PIN_LVTTL_O(lvttl), .PIN_SLOW_O(slow), .IRQ_O(irq));

    gppc_ext_model u_ext (.clk_i(clk), .pin_o_i(pin_o), .oe_i(oe), .pu_i(pu), .pd_i(pd),
        .drv_en_i(ext_en), .drv_val_i(ext_val), .pin_i_o(pin_i));

    always #10 clk = ~clk;

    // ----------------------------------------------------------------
    // bus and checking helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // wait until pready is seen high; only the watchdog ends a wait that hangs
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input int p, input logic [5:0] o, input logic [31:0] d);
        apb(1'b1, {3'h0, 3'(p), o}, d);
        if (o != `GPPC_OFS_ICLR)
            m_reg[p][o[5:2]] = d;
    endtask : wr

    task automatic rd(input int p, input logic [5:0] o, input logic [31:0] e, input string nm);
        apb(1'b0, {3'h0, 3'(p), o}, 32'h0);
        `CHK(nm, e, rdata)
    endtask : rd

    // expected pad controls from the register model
    task automatic chk_pins(input int p);
        logic [7:0]  eo, eu, ed, ei, ev;
        logic [39:0] src;
        int          m, s;
        logic        v, ob;
        for (int n = 0; n < 8; n++)
        begin
            m  = (m_reg[p][2] >> (3 * n)) & 7;
            s  = (m_reg[p][5] >> (2 * n)) & 3;
            src = s == 0 ? 40'(m_reg[p][0] & 255) << (8 * p) : s == 1 ? alt1 : s == 2 ? alt2 : alt3;
            v  = src[8 * p + n];
            ob = m_reg[p][3][8 + n] & impl[8 * p + n];
            eo[n] = ob & (m == 6 | (m == 2 | m == 4) & !v | (m == 3 | m == 5) & v);
            eu[n] = ob & v & (m == 2 | m == 7);
            ed[n] = ob & !v & (m == 3 | m == 7);
            ei[n] = m_reg[p][3][n] & impl[8 * p + n] & (m != 0);
            ev[n] = v & eo[n];
        end
        `CHK("oe", eo, oe[8 * p +: 8])
        `CHK("pu", eu, pu[8 * p +: 8])
        `CHK("pd", ed, pd[8 * p +: 8])
        `CHK("ie", ei, ie[8 * p +: 8])
        `CHK("val", ev, pin_o[8 * p +: 8] & oe[8 * p +: 8])
    endtask : chk_pins

    function automatic logic [7:0] hits(logic [15:0] e, logic [7:0] o, logic [7:0] n);
        for (int i = 0; i < 8; i++)
            hits[i] = e[2 * i] & !o[i] & n[i] | e[2 * i + 1] & o[i] & !n[i];
    endfunction : hits

    initial
    begin
        #(20 * 30000);
        n_errors++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 0; pwdata = 0;
        alt1 = 0; alt2 = 0; alt3 = 0; ext_en = 0; ext_val = 0; n_errors = 0; tests_run = 0;
        m_reg = '{default: 0};
        void'($urandom(71625));
        repeat (5) @(posedge clk);
        `CHK("rst_pads", 40'h0, oe | pu | pd | ie)
        `CHK("rst_irq", 5'h0, irq)
        rst <= 1'b0;
        for (int p = 0; p < 5; p++)
            for (int o = 0; o < 10; o++)
                if (o != 1)
                    rd(p, 6'(4 * o), 32'h0, "rstval");
        apb(1'b0, 12'h140, 32'h0);
        `CHK("err_p5", 1'b1, err)
        `CHK("rd_p5", 32'h0, rdata)
        apb(1'b1, 12'h600, 32'hFF);
        `CHK("err_hi", 1'b1, err)
        for (int p = 1; p < 3; p++)
            for (int m = 0; m < 8; m++)
            begin
                wr(p, `GPPC_OFS_BUF, 16'($urandom) | (m[0] ? 16'hFF00 : 16'h0));
                wr(p, `GPPC_OFS_MODE, 24'(m * 24'h249249));
                wr(p, `GPPC_OFS_DOUT, 8'($urandom));
                wr(p, `GPPC_OFS_MUX, 16'($urandom));
                alt1 <= 40'({$urandom, $urandom});
                alt2 <= 40'({$urandom, $urandom});
                alt3 <= 40'({$urandom, $urandom});
                repeat (2) @(posedge clk);
                chk_pins(p);
                rd(p, `GPPC_OFS_MODE, 32'(m_reg[p][2]), "mode");
            end
        for (int k = 0; k < 10; k++)
        begin
            wr(k % 5, `GPPC_OFS_CFG, k < 5 ? 32'h1 : 32'h2);
            repeat (2) @(posedge clk);
            `CHK("lvttl", k < 5, lvttl[k % 5])
            `CHK("slow", k >= 5, slow[k % 5])
        end
        // reset in mid-run must drop every configured buffer at once
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("mid_rst", 40'h0, oe | pu | pd | ie)
        `CHK("mid_slow", 5'h0, slow)
        rst <= 1'b0;
        m_reg = '{default: 0};
        rd(1, `GPPC_OFS_MODE, 32'h0, "mid_mode");
        wr(4, `GPPC_OFS_MODE, 24'h249249);
        wr(4, `GPPC_OFS_BUF, 16'h00FF);
        ext_en[39:32] <= 8'hFF;
        for (int k = 0; k < 4; k++)
        begin
            ext_val[39:32] <= 8'($urandom);
            repeat (5) @(posedge clk);
            rd(4, `GPPC_OFS_STATE, 32'(ext_val[39:32]), "state");
        end
        apb(1'b1, 12'h104, 32'hFF);
        `CHK("err_ro", 1'b0, err)
        wr(4, `GPPC_OFS_BUF, 16'h000F);
        repeat (4) @(posedge clk);
        rd(4, `GPPC_OFS_STATE, 32'(ext_val[35:32]), "state_ib");
        wr(3, `GPPC_OFS_MODE, 24'h000249);
        wr(3, `GPPC_OFS_BUF, 16'h000F);
        ext_en[27:24] <= 4'hF;
        wr(3, `GPPC_OFS_EDGE, 16'h00E4);
        repeat (6) @(posedge clk);
        wr(3, `GPPC_OFS_ICLR, 32'hFF);
        rd(3, `GPPC_OFS_ISTAT, 32'h0, "istat0");
        wr(3, `GPPC_OFS_IEN, 32'h0F);
        for (int k = 0; k < 2; k++)
        begin
            ext_val[27:24] <= k ? 4'h0 : 4'hF;
            repeat (8) @(posedge clk);
            rd(3, `GPPC_OFS_ISTAT, 32'(hits(16'hE4, k ? 8'hF : 8'h0, k ? 8'h0 : 8'hF)),
               "istat");
            `CHK("irq_on", 5'b01000, irq)
            wr(3, `GPPC_OFS_IEN, 32'h0);
            repeat (3) @(posedge clk);
            `CHK("irq_mask", 5'h0, irq)
            wr(3, `GPPC_OFS_ICLR, 32'h02);
            rd(3, `GPPC_OFS_ISTAT, 32'(hits(16'hE4, k ? 8'hF : 8'h0, k ? 8'h0 : 8'hF) & 8'hFD),
               "iclr");
            wr(3, `GPPC_OFS_ICLR, 32'hFF);
            wr(3, `GPPC_OFS_IEN, 32'h0F);
            repeat (3) @(posedge clk);
            `CHK("irq_clr", 5'h0, irq)
        end
        // pin edge reaches the flags on the very edge the clear lands
        fork
            wr(3, `GPPC_OFS_ICLR, 32'h02);
            begin
                @(posedge clk);
                ext_val[27:24] <= 4'hF;
            end
        join
        repeat (4) @(posedge clk);
        rd(3, `GPPC_OFS_ISTAT, 32'(hits(16'hE4, 8'h0, 8'hF)), "set_wins");
        rd(3, `GPPC_OFS_ICLR, 32'h0, "iclr_rd");
        wrap_up();
    end

endmodule : gpio_port_pin_control_tb

`default_nettype wire
